// >>> shiftload_mem_model.sv
// memory system model answering user-rights and plain load reads
`timescale 1ns/100ps
module shiftload_mem_model #(
	parameter logic [31:0] KEY = 32'h5A3C_96E1
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic req, // read request pulse
	input wire logic [31:0] addr, // read address
	input wire logic [1:0] size, // 1 half, 2 word
	input wire logic [3:0] dly, // extra wait cycles before answer
	output logic ready, // answer pulse
	output logic [31:0] rdata // answer data
);
	logic pend_r;
	logic [3:0] cnt_r;
	logic [31:0] addr_r;
	logic [1:0] size_r;
	logic [31:0] word;

	// memory content is the address scrambled by a fixed key
	assign word = addr_r ^ KEY;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_r <= 1'b0;
			cnt_r <= 4'h0;
			addr_r <= 32'h0;
			size_r <= 2'h0;
			ready <= 1'b0;
			rdata <= 32'h0;
		end else begin
			ready <= 1'b0;
			// data lines invert their value every cycle between answers
			rdata <= ~rdata;
			if (req) begin
				pend_r <= 1'b1;
				cnt_r <= dly;
				addr_r <= addr;
				size_r <= size;
			end else if (pend_r && cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				ready <= 1'b1;
				// a half answer leaves junk in the upper lanes
				if (size_r == 2'h1) begin
					rdata <= {~word[31:16], word[15:0]};
				end else begin
					rdata <= word;
				end
			end
		end
	end
endmodule : shiftload_mem_model

// >>> shiftload_params.svh
// constants for the user-rights load and logical shift unit
`ifndef SHIFTLOAD_PARAMS_SVH
`define SHIFTLOAD_PARAMS_SVH

// ----------------------------------------------------------------
// encoding, datapath and reset constants
// ----------------------------------------------------------------
`define HW_LOAD_HI 12'hF93
`define WD_LOAD_HI 12'hF85
`define USER_SUFFIX 4'hE
`define PC_REG 4'hF
`define SP_REG 4'hD
`define SHL16_OP 5'h00
`define SHR16_OP 5'h01
`define SHLR16_OP 10'h102
`define SHI32_HI 11'h752
`define SHI32_MASK 4'hF
`define SHLR32_HI 11'h7D0
`define SR_SHL 2'h0
`define SR_SHR 2'h1
`define RESULT_MSB 31
`define AMT_BITS 8
`define FLAGS_RESET 4'h0

`endif

// >>> shiftload_pkg.sv
// types for the user-rights load and logical shift unit
package shiftload_pkg;
	typedef enum {
		OP_NONE,
		OP_HALF_USER,
		OP_WORD_USER,
		OP_HALF_PCREL,
		OP_WORD_PCREL,
		OP_MOVE,
		OP_SHL_IMM,
		OP_SHR_IMM,
		OP_SHL_REG
	} op_t;
	typedef enum {ST_IDLE, ST_LOAD} state_t;
endpackage : shiftload_pkg

// >>> shiftload_regfile.sv
// sixteen-word register bank with registered read ports
`timescale 1ns/100ps
module shiftload_regfile #(
	parameter int WIDTH = 32
) (
	input wire logic clk, // clock
	input wire logic we, // write enable
	input wire logic [3:0] waddr, // write index
	input wire logic [WIDTH-1:0] wdata, // write data
	input wire logic [3:0] raddr_a, // read index a
	input wire logic [3:0] raddr_b, // read index b
	output logic [WIDTH-1:0] rdata_a, // registered data a
	output logic [WIDTH-1:0] rdata_b // registered data b
);
	logic [WIDTH-1:0] mem [16];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule : shiftload_regfile

// >>> shiftload_unit.sv
// decoder and executor for user-rights loads and logical shifts
`timescale 1ns/100ps
`include "shiftload_params.svh"
module shiftload_unit (
	input wire logic SYS_CLK, // 40 MHz clock
	input wire logic RST, // async reset, high
	input wire logic INSTR_VALID, // instruction strobe, one cycle
	input wire logic [31:0] INSTR, // hw1 in 31:16, hw2 in 15:0
	input wire logic IS_WIDE, // 32-bit encoding
	input wire logic COND_PASS, // condition check passed
	input wire logic INSIDE_CONDITIONAL_BLOCK, // inside conditional block
	input wire logic [31:0] PC_VALUE, // current PC
	input wire logic [3:0] WR_IDX, // software register write index
	input wire logic [31:0] WR_DATA, // software register write data
	input wire logic WR_EN, // software register write strobe
	input wire logic MEM_READY, // memory read answer strobe
	input wire logic [31:0] MEM_RDATA, // memory read data
	output logic MEM_REQ, // memory read request
	output logic [31:0] MEM_ADDR, // memory address
	output logic [1:0] MEM_SIZE, // 1 half, 2 word
	output logic MEM_USER_RIGHTS, // unprivileged checks
	output logic RES_VALID, // result written pulse
	output logic [3:0] RES_IDX, // destination index
	output logic [31:0] RES_DATA, // destination value
	output logic BUSY, // load waiting for memory answer
	output logic [3:0] APPLICATION_STATUS_WORD // N Z C V
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	shiftload_pkg::op_t op;
	logic [15:0] hw1;
	logic [15:0] hw2;
	logic [3:0] dst;
	logic [3:0] src_a;
	logic [3:0] src_b;
	logic [4:0] shift_amount_field;
	logic [7:0] byte_offset_field;
	logic [11:0] imm12;
	logic set_flags;
	logic dec_user;

	assign hw1 = INSTR[31:16];
	assign hw2 = INSTR[15:0];
	assign byte_offset_field = hw2[7:0];
	assign imm12 = hw2[11:0];

	always_comb begin
		op = shiftload_pkg::OP_NONE;
		dst = 4'h0;
		src_a = 4'h0;
		src_b = 4'h0;
		shift_amount_field = 5'h00;
		set_flags = 1'b0;
		dec_user = 1'b0;
		if (IS_WIDE) begin
			dst = hw2[15:12];
			src_a = hw1[3:0];
			if (hw1[15:4] == `HW_LOAD_HI && hw2[11:8] == `USER_SUFFIX) begin
				if (hw1[3:0] == `PC_REG) begin
					op = shiftload_pkg::OP_HALF_PCREL;
				end else begin
					op = shiftload_pkg::OP_HALF_USER;
					dec_user = 1'b1;
				end
			end else if (hw1[15:4] == `WD_LOAD_HI
					&& hw2[11:8] == `USER_SUFFIX) begin
				if (hw1[3:0] == `PC_REG) begin
					op = shiftload_pkg::OP_WORD_PCREL;
				end else begin
					op = shiftload_pkg::OP_WORD_USER;
					dec_user = 1'b1;
				end
			end else if (hw1[15:5] == `SHI32_HI && hw1[3:0] == `SHI32_MASK
					&& hw2[15] == 1'b0) begin
				dst = hw2[11:8];
				src_a = hw2[3:0];
				set_flags = hw1[4];
				shift_amount_field = {hw2[14:12], hw2[7:6]};
				if (hw2[5:4] == `SR_SHL) begin
					op = (shift_amount_field == 5'h00) ?
						shiftload_pkg::OP_MOVE : shiftload_pkg::OP_SHL_IMM;
				end else if (hw2[5:4] == `SR_SHR) begin
					op = shiftload_pkg::OP_SHR_IMM;
				end
			end else if (hw1[15:5] == `SHLR32_HI && hw2[15:12] == 4'hF
					&& hw2[7:4] == 4'h0) begin
				dst = hw2[11:8];
				src_a = hw1[3:0];
				src_b = hw2[3:0];
				set_flags = hw1[4];
				op = shiftload_pkg::OP_SHL_REG;
			end
		end else begin
			set_flags = ~INSIDE_CONDITIONAL_BLOCK;
			dst = {1'b0, hw1[2:0]};
			src_a = {1'b0, hw1[5:3]};
			shift_amount_field = hw1[10:6];
			if (hw1[15:11] == `SHL16_OP) begin
				if (shift_amount_field == 5'h00) begin
					op = shiftload_pkg::OP_MOVE;
					set_flags = 1'b0;
				end else begin
					op = shiftload_pkg::OP_SHL_IMM;
				end
			end else if (hw1[15:11] == `SHR16_OP) begin
				op = shiftload_pkg::OP_SHR_IMM;
			end else if (hw1[15:6] == `SHLR16_OP) begin
				src_a = {1'b0, hw1[2:0]};
				src_b = {1'b0, hw1[5:3]};
				op = shiftload_pkg::OP_SHL_REG;
			end
		end
	end

	// ----------------------------------------------------------------
	// shifter functions
	// ----------------------------------------------------------------
	// returns {carry, result}; amount 0 keeps value and carry
	function automatic logic [32:0] shl_c(input logic [31:0] v,
			input logic [7:0] n, input logic c_in);
		logic [63:0] ext;
		ext = 64'h0;
		if (n == 8'h00) begin
			shl_c = {c_in, v};
		end else if (n > 8'h20) begin
			shl_c = 33'h0;
		end else begin
			ext = {32'h0, v} << n;
			shl_c = {ext[32], ext[31:0]};
		end
	endfunction : shl_c

	function automatic logic [32:0] shr_c(input logic [31:0] v,
			input logic [5:0] n);
		logic [63:0] ext;
		ext = {v, 32'h0} >> n;
		shr_c = {ext[31], ext[63:32]};
	endfunction : shr_c

	// ----------------------------------------------------------------
	// pipeline: decode stage registers, then execute on read data
	// ----------------------------------------------------------------
	logic [31:0] rd_a;
	logic [31:0] rd_b;
	logic we;
	logic [3:0] we_idx;
	logic [31:0] we_data;
	shiftload_pkg::state_t state_r;
	logic ex_r;
	shiftload_pkg::op_t op_r;
	logic [3:0] dst_r;
	logic [4:0] amt_r;
	logic [7:0] off_r;
	logic [11:0] imm12_r;
	logic [31:0] pc_r;
	logic flags_r;
	logic user_r;
	logic [32:0] sh;
	logic [3:0] flags_nxt;

	assign we = WR_EN | (RES_VALID & ~BUSY);
	assign we_idx = WR_EN ? WR_IDX : RES_IDX;
	assign we_data = WR_EN ? WR_DATA : RES_DATA;

	shiftload_regfile #(.WIDTH(32)) u_regs (
		.clk(SYS_CLK),
		.we(we),
		.waddr(we_idx),
		.wdata(we_data),
		.raddr_a(src_a),
		.raddr_b(src_b),
		.rdata_a(rd_a),
		.rdata_b(rd_b)
	);

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ex_r <= 1'b0;
			op_r <= shiftload_pkg::OP_NONE;
			dst_r <= 4'h0;
			amt_r <= 5'h00;
			off_r <= 8'h00;
			imm12_r <= 12'h000;
			pc_r <= 32'h0;
			flags_r <= 1'b0;
			user_r <= 1'b0;
		end else begin
			ex_r <= INSTR_VALID & COND_PASS & ~BUSY
				& (op != shiftload_pkg::OP_NONE);
			op_r <= op;
			dst_r <= dst;
			amt_r <= shift_amount_field;
			off_r <= byte_offset_field;
			imm12_r <= imm12;
			pc_r <= PC_VALUE;
			flags_r <= set_flags;
			user_r <= dec_user;
		end
	end

	always_comb begin
		sh = {APPLICATION_STATUS_WORD[1], rd_a};
		case (op_r)
			shiftload_pkg::OP_SHL_IMM: sh = shl_c(rd_a, {3'h0, amt_r},
				APPLICATION_STATUS_WORD[1]);
			shiftload_pkg::OP_SHR_IMM: sh = shr_c(rd_a,
				(amt_r == 5'h00) ? 6'h20 : {1'b0, amt_r});
			shiftload_pkg::OP_SHL_REG: sh = shl_c(rd_a,
				rd_b[`AMT_BITS-1:0], APPLICATION_STATUS_WORD[1]);
			default: sh = {APPLICATION_STATUS_WORD[1], rd_a};
		endcase
	end

	// ----------------------------------------------------------------
	// memory request and load completion
	// ----------------------------------------------------------------
	logic is_load;
	assign is_load = (op_r == shiftload_pkg::OP_HALF_USER)
		|| (op_r == shiftload_pkg::OP_WORD_USER)
		|| (op_r == shiftload_pkg::OP_HALF_PCREL)
		|| (op_r == shiftload_pkg::OP_WORD_PCREL);

	logic half_r;
	logic [3:0] ld_dst_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_r <= shiftload_pkg::ST_IDLE;
			MEM_REQ <= 1'b0;
			MEM_ADDR <= 32'h0;
			MEM_SIZE <= 2'h0;
			MEM_USER_RIGHTS <= 1'b0;
			half_r <= 1'b0;
			ld_dst_r <= 4'h0;
			BUSY <= 1'b0;
		end else begin
			MEM_REQ <= 1'b0;
			case (state_r)
				shiftload_pkg::ST_IDLE: begin
					if (ex_r && is_load) begin
						MEM_REQ <= 1'b1;
						if (op_r == shiftload_pkg::OP_HALF_PCREL
								|| op_r == shiftload_pkg::OP_WORD_PCREL) begin
							MEM_ADDR <= {pc_r[31:2], 2'h0} + {20'h0, imm12_r};
						end else begin
							MEM_ADDR <= rd_a + {24'h0, off_r};
						end
						MEM_SIZE <= (op_r == shiftload_pkg::OP_HALF_USER
							|| op_r == shiftload_pkg::OP_HALF_PCREL) ? 2'h1 : 2'h2;
						half_r <= (op_r == shiftload_pkg::OP_HALF_USER
							|| op_r == shiftload_pkg::OP_HALF_PCREL);
						MEM_USER_RIGHTS <= user_r;
						ld_dst_r <= dst_r;
						BUSY <= 1'b1;
						state_r <= shiftload_pkg::ST_LOAD;
					end
				end
				shiftload_pkg::ST_LOAD: begin
					if (MEM_READY) begin
						BUSY <= 1'b0;
						state_r <= shiftload_pkg::ST_IDLE;
					end
				end
				default: state_r <= shiftload_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// result write and flags
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			RES_VALID <= 1'b0;
			RES_IDX <= 4'h0;
			RES_DATA <= 32'h0;
		end else begin
			RES_VALID <= 1'b0;
			if (state_r == shiftload_pkg::ST_LOAD && MEM_READY) begin
				RES_VALID <= 1'b1;
				RES_IDX <= ld_dst_r;
				RES_DATA <= half_r ? {{16{MEM_RDATA[15]}}, MEM_RDATA[15:0]}
					: MEM_RDATA;
			end else if (ex_r && !is_load) begin
				RES_VALID <= 1'b1;
				RES_IDX <= dst_r;
				RES_DATA <= sh[31:0];
			end
		end
	end

	always_comb begin
		flags_nxt = APPLICATION_STATUS_WORD;
		if (ex_r && !is_load && flags_r) begin
			flags_nxt = {sh[`RESULT_MSB], (sh[31:0] == 32'h0), sh[32],
				APPLICATION_STATUS_WORD[0]};
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			APPLICATION_STATUS_WORD <= `FLAGS_RESET;
		end else begin
			APPLICATION_STATUS_WORD <= flags_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_overflow_kept: assert property (@(posedge SYS_CLK) disable iff (RST)
		APPLICATION_STATUS_WORD[0] == $past(APPLICATION_STATUS_WORD[0]))
		else $error("overflow flag changed");
	chk_fail_no_req: assert property (@(posedge SYS_CLK) disable iff (RST)
		INSTR_VALID && !COND_PASS && !BUSY |-> ##2 !MEM_REQ)
		else $error("memory request after failed condition");
	chk_user_half_req: assert property (@(posedge SYS_CLK) disable iff (RST)
		MEM_REQ && MEM_SIZE == 2'h1 && MEM_USER_RIGHTS |-> !BUSY == 1'b0)
		else $error("half load request without busy");
	chk_half_sign: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_r == shiftload_pkg::ST_LOAD && MEM_READY && half_r |=>
		RES_VALID && RES_DATA[31:16] == {16{RES_DATA[15]}})
		else $error("half load not sign-extended");
	chk_word_pass: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_r == shiftload_pkg::ST_LOAD && MEM_READY && !half_r |=>
		RES_DATA == $past(MEM_RDATA))
		else $error("word load altered");
	chk_zero_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
		ex_r && !is_load && flags_r |=>
		APPLICATION_STATUS_WORD[2] == (RES_DATA == 32'h0)
		&& APPLICATION_STATUS_WORD[3] == RES_DATA[31])
		else $error("N or Z flag wrong");
	chk_no_flag_upd: assert property (@(posedge SYS_CLK) disable iff (RST)
		ex_r && !flags_r |=> $stable(APPLICATION_STATUS_WORD))
		else $error("flags changed without update");
	chk_shr32_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
		ex_r && op_r == shiftload_pkg::OP_SHR_IMM && amt_r == 5'h00 |=>
		RES_DATA == 32'h0)
		else $error("right shift by 32 not zero");
endmodule : shiftload_unit

// >>> tb.sv
// self-checking bench for the user-rights load and logical shift unit
`timescale 1ns/100ps
module tb;
	localparam logic [31:0] KEY = 32'h5A3C_96E1;
	logic sys_clk, rst, instr_valid, is_wide, cond_pass, inblk, wr_en;
	logic [31:0] instr, pc_value, wr_data, mem_rdata, mem_addr, res_data;
	logic [3:0] wr_idx, res_idx, asw, mem_dly, ri, flg;
	logic mem_ready, mem_req, user_rights, res_valid, busy, mu, pk, bz;
	logic [1:0] mem_size, ms;
	logic [31:0] mismatches, n_tests, nreq, nres, ma, rd;

	shiftload_unit u_dut (.SYS_CLK(sys_clk), .RST(rst),
		.INSTR_VALID(instr_valid), .INSTR(instr), .IS_WIDE(is_wide),
		.COND_PASS(cond_pass), .INSIDE_CONDITIONAL_BLOCK(inblk),
		.PC_VALUE(pc_value), .WR_IDX(wr_idx), .WR_DATA(wr_data),
		.WR_EN(wr_en), .MEM_READY(mem_ready), .MEM_RDATA(mem_rdata),
		.MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_SIZE(mem_size),
		.MEM_USER_RIGHTS(user_rights), .RES_VALID(res_valid),
		.RES_IDX(res_idx), .RES_DATA(res_data), .BUSY(busy),
		.APPLICATION_STATUS_WORD(asw));

	shiftload_mem_model #(.KEY(KEY)) u_mem (.clk(sys_clk), .rst(rst),
		.req(mem_req), .addr(mem_addr), .size(mem_size), .dly(mem_dly),
		.ready(mem_ready), .rdata(mem_rdata));

	always #12.5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 32'h1;
		if (got !== exp) begin
			mismatches = mismatches + 32'h1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		if (mismatches == 32'h0 && n_tests != 32'h0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		@(posedge sys_clk);
		wr_idx <= i;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// offers one instruction and watches a fixed window of 16 cycles
	task automatic run(input logic [31:0] ins, input logic w, c, b, poke);
		@(posedge sys_clk);
		instr <= ins;
		is_wide <= w;
		cond_pass <= c;
		inblk <= b;
		instr_valid <= 1'b1;
		pk = 1'b0;
		nreq = 32'h0;
		nres = 32'h0;
		repeat (16) begin
			@(posedge sys_clk);
			instr_valid <= pk;
			pk = 1'b0;
			#1;
			if (mem_req === 1'b1) begin
				nreq = nreq + 32'h1;
				ma = mem_addr;
				ms = mem_size;
				mu = user_rights;
				bz = busy;
				// reoffer while busy: must be ignored
				pk = poke && nreq == 32'h1;
			end
			if (res_valid === 1'b1) begin
				nres = nres + 32'h1;
				rd = res_data;
				ri = res_idx;
			end
		end
	endtask : run

	task automatic ld(input logic w, input logic [3:0] rn,
		input logic [31:0] bv, input logic [3:0] rt, input logic [7:0] imm,
		input logic [3:0] dl, input logic poke);
		logic [31:0] ea;
		logic [31:0] d;
		if (rn != 4'hF) wr(rn, bv);
		@(posedge sys_clk);
		pc_value <= bv;
		mem_dly <= dl;
		if (rn == 4'hF) ea = {bv[31:2], 2'h0} + {20'h0, 4'hE, imm};
		else ea = bv + {24'h0, imm};
		d = ea ^ KEY;
		if (!w) d = {{16{d[15]}}, d[15:0]};
		run({w ? 12'hF85 : 12'hF93, rn, rt, 4'hE, imm}, 1'b1, 1'b1, 1'b0,
			poke);
		chk(nreq, 32'h1);
		chk(ma, ea);
		chk({30'h0, ms}, w ? 32'h2 : 32'h1);
		chk({31'h0, mu}, {31'h0, rn != 4'hF});
		chk({31'h0, bz}, 32'h1);
		chk({31'h0, busy}, 32'h0);
		chk(nres, 32'h1);
		chk(rd, d);
		chk({28'h0, ri}, {28'h0, rt});
	endtask : ld

	task automatic sh(input logic [31:0] ins, input logic w, b, setf,
		input logic [31:0] er, input logic [3:0] ei, input logic ec);
		run(ins, w, 1'b1, b, 1'b0);
		if (setf) flg = {er[31], er == 32'h0, ec, flg[0]};
		chk(nres, 32'h1);
		chk(rd, er);
		chk({28'h0, ri}, {28'h0, ei});
		chk({28'h0, asw}, {28'h0, flg});
	endtask : sh

	task automatic nop_chk(input logic [31:0] ins, input logic w);
		run(ins, w, 1'b0, 1'b0, 1'b0);
		chk(nreq, 32'h0);
		chk(nres, 32'h0);
		chk({28'h0, asw}, {28'h0, flg});
	endtask : nop_chk

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches = 32'h0;
		n_tests = 32'h0;
		flg = 4'h0;
		sys_clk = 1'b0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 32'h0;
		is_wide = 1'b0;
		cond_pass = 1'b0;
		inblk = 1'b0;
		pc_value = 32'h0;
		wr_idx = 4'h0;
		wr_data = 32'h0;
		wr_en = 1'b0;
		mem_dly = 4'h0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk({28'h0, asw}, 32'h0);
		chk({31'h0, busy}, 32'h0);
		// destinations avoid 13 and 15 throughout
		ld(1'b0, 4'h3, 32'h1000_0100, 4'h5, 8'hFF, 4'h0, 1'b0);
		ld(1'b1, 4'hD, 32'h2000_0040, 4'h6, 8'h00, 4'h3, 1'b1);
		ld(1'b0, 4'hF, 32'h0000_3006, 4'h4, 8'h21, 4'h1, 1'b0);
		ld(1'b1, 4'hF, 32'h0000_3007, 4'h7, 8'h80, 4'h6, 1'b0);
		wr(4'h1, 32'h8000_0003);
		sh({5'h00, 5'h01, 3'h1, 3'h2, 16'h0}, 1'b0, 1'b0, 1'b1,
			32'h6, 4'h2, 1'b1);
		sh({5'h00, 5'h1F, 3'h1, 3'h3, 16'h0}, 1'b0, 1'b1, 1'b0,
			32'h8000_0000, 4'h3, 1'b1);
		sh({5'h00, 5'h00, 3'h1, 3'h4, 16'h0}, 1'b0, 1'b0, 1'b0,
			32'h8000_0003, 4'h4, 1'b0);
		sh({5'h01, 5'h00, 3'h1, 3'h5, 16'h0}, 1'b0, 1'b0, 1'b1,
			32'h0, 4'h5, 1'b1);
		sh({5'h01, 5'h04, 3'h1, 3'h6, 16'h0}, 1'b0, 1'b0, 1'b1,
			32'h0800_0000, 4'h6, 1'b0);
		nop_chk({5'h00, 5'h02, 3'h1, 3'h1, 16'h0}, 1'b0);
		nop_chk({12'hF85, 4'h3, 4'h5, 4'hE, 8'h10}, 1'b1);
		wr(4'h0, 32'h0000_0120);
		wr(4'h7, 32'h1);
		sh({10'h102, 3'h0, 3'h7, 16'h0}, 1'b0, 1'b0, 1'b1,
			32'h0, 4'h7, 1'b1);
		wr(4'h0, 32'h21);
		wr(4'h7, 32'h1);
		sh({10'h102, 3'h0, 3'h7, 16'h0}, 1'b0, 1'b0, 1'b1,
			32'h0, 4'h7, 1'b0);
		wr(4'h9, 32'hF000_0001);
		sh({11'h752, 1'b1, 4'hF, 1'b0, 3'h1, 4'h8, 2'h0, 2'h0, 4'h9},
			1'b1, 1'b0, 1'b1, 32'h10, 4'h8, 1'b1);
		sh({11'h752, 1'b0, 4'hF, 1'b0, 3'h2, 4'hA, 2'h0, 2'h1, 4'h9},
			1'b1, 1'b0, 1'b0, 32'h00F0_0000, 4'hA, 1'b0);
		wr(4'h0, 32'h1);
		wr(4'hB, 32'h4000_0000);
		sh({11'h7D0, 1'b1, 4'hB, 4'hF, 4'hC, 4'h0, 4'h0}, 1'b1, 1'b1,
			1'b1, 32'h8000_0000, 4'hC, 1'b0);
		print_verdict();
	end
endmodule : tb
